// *** psde_regs.vh ***
/*
  Constants for the presence-detect EEPROM slave: select codes, descriptor
  offsets and values, and timing.
  Assumes inclusion by psde_top.v only, by bare name.
*/
// What this block does
// - Bytes travel most significant bit first.
// - Array select code 1010, straps, direction.
// - Protection select code 0110, straps, direction.
// - Current read returns byte at pointer.
// - Random read: address write, restart, read.
// - Keep sending bytes while master acknowledges.
// - Writes only with write control low; 16-byte page.
// - Internal program cycle ends within 10 ms.
// - During program cycle ignore bus, release data.
// - Byte 0 reads 80h, byte 1 08h.
// - Fixed bytes 2,5,6,7,8,11,14.
// - Byte 3 row count by density.
// - Byte 4 column count by density.
// - Acknowledge select, and each written byte while write control is low.
// - On master no-acknowledge, stop sending and await the next start.
`ifndef PSDE_REGS_VH
`define PSDE_REGS_VH

// ----------------------------------------------------------------------------
// Select codes and page.
// ----------------------------------------------------------------------------
`define PSDE_DEVTYPE_ARRAY 4'hA
`define PSDE_DEVTYPE_PROT  4'h6
`define PSDE_PAGE_BITS     4

// ----------------------------------------------------------------------------
// Descriptor offsets.
// ----------------------------------------------------------------------------
`define PSDE_OFS_BYTES_USED_COUNT    4'h0
`define PSDE_OFS_TOTAL_SIZE_CODE     4'h1
`define PSDE_OFS_MEMORY_TYPE_CODE    4'h2
`define PSDE_OFS_ROW_ADDRESS_COUNT   4'h3
`define PSDE_OFS_COLUMN_ADDR_COUNT   4'h4
`define PSDE_OFS_RANK_COUNT          4'h5
`define PSDE_OFS_DATA_WIDTH_LOW      4'h6
`define PSDE_OFS_DATA_WIDTH_HIGH     4'h7
`define PSDE_OFS_SIGNAL_LEVEL_CODE   4'h8
`define PSDE_OFS_CYCLE_TIME_MAX_LAT  4'h9
`define PSDE_OFS_ACCESS_TIME_MAX_LAT 4'hA
`define PSDE_OFS_MODULE_CONFIG_TYPE  4'hB
`define PSDE_OFS_REFRESH_RATE_TYPE   4'hC
`define PSDE_OFS_DEVICE_WIDTH        4'hD
`define PSDE_OFS_CHECK_DATA_WIDTH    4'hE
`define PSDE_ROM_SIZE                8'h0F

// ----------------------------------------------------------------------------
// Descriptor values.
// ----------------------------------------------------------------------------
`define PSDE_RST_BYTES_USED_COUNT   8'h80
`define PSDE_RST_TOTAL_SIZE_CODE    8'h08
`define PSDE_RST_MEMORY_TYPE_CODE   8'h07
`define PSDE_RST_ROW_SMALL          8'h0C
`define PSDE_RST_ROW_LARGE          8'h0D
`define PSDE_RST_COL_SMALL          8'h0A
`define PSDE_RST_COL_LARGE          8'h0B
`define PSDE_RST_RANK_COUNT         8'h01
`define PSDE_RST_DATA_WIDTH_LOW     8'h40
`define PSDE_RST_DATA_WIDTH_HIGH    8'h00
`define PSDE_RST_SIGNAL_LEVEL_CODE  8'h04
`define PSDE_RST_MODULE_CONFIG_TYPE 8'h00
`define PSDE_RST_CHECK_DATA_WIDTH   8'h00
`define PSDE_RST_REFRESH_SMALL      8'h80
`define PSDE_RST_REFRESH_LARGE      8'h82
`define PSDE_RST_CYCLE_TIME         8'h60
`define PSDE_RST_ACCESS_TIME        8'h70
`define PSDE_RST_DEVICE_WIDTH       8'h08
`define PSDE_RST_ERASED             8'hFF

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define PSDE_CLK_PERIOD_NS   10
`define PSDE_PROG_TIME_MS    10
`define PSDE_PROG_CYCLES     (`PSDE_PROG_TIME_MS * 1000000 / `PSDE_CLK_PERIOD_NS)

`endif

// *** psde_sync.v ***
/*
  Two-flip-flop synchroniser for a group of level inputs.
  Assumes inputs asynchronous to clk; sys_rst is synchronous, active high.
*/
module psde_sync #(
  parameter W       = 1,
  parameter RST_VAL = 1'b1
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= {W{RST_VAL}};
      q      <= {W{RST_VAL}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// *** psde_top.v ***
/*
  Presence-detect serial EEPROM slave: two-wire bus front end, 256-byte
  store with read-only descriptor bytes 0 to 14, protection byte, page
  buffer and self-timed program cycle.
  Assumes scl and pins arrive asynchronously and are oversampled by clk,
  and that the bench resolves the open-drain data wire from sda_oe.
  Each phase of scl must last at least four clk periods, because scl and the data
  pin each pass two synchroniser stages and one edge-finding stage before use.
  The data pin is open drain: sda_out is always low and sda_oe pulls the
  wire down, so the wire is expected to carry a pull-up outside.
  The store has no reset of its own; cells above the descriptor start erased.
*/
`include "psde_regs.vh"

module psde_top #(
  parameter DENSITY     = 0,
  parameter CYCLE_BYTE  = `PSDE_RST_CYCLE_TIME,
  parameter ACCESS_BYTE = `PSDE_RST_ACCESS_TIME,
  parameter PROG_CYCLES = `PSDE_PROG_CYCLES,
  parameter CW          = 20
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire scl,
  input  wire sda_in,
  output wire sda_out,
  output reg  sda_oe,
  input  wire strap_bit_zero,
  input  wire strap_bit_one,
  input  wire strap_bit_two,
  input  wire write_control,
  output wire write_busy
);

  // --------------------------------------------------------------------------
  // Bus states.
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_TX   = 3'h3;
  localparam [2:0] ST_MACK = 3'h4;

  localparam [1:0] RL_SEL  = 2'h0;
  localparam [1:0] RL_ADDR = 2'h1;
  localparam [1:0] RL_DATA = 2'h2;

  localparam [CW-1:0] PROG_LOAD = PROG_CYCLES[CW-1:0];
  localparam integer  PAGE      = 1 << `PSDE_PAGE_BITS;

  // --------------------------------------------------------------------------
  // Input synchronisation and edge finding.
  // --------------------------------------------------------------------------
  wire [5:0] sync_w;
  wire       scl_s;
  wire       sda_s;
  wire [2:0] strap_s;
  wire       wc_s;
  reg        scl_d_q;
  reg        sda_d_q;

  psde_sync #(
    .W       (6),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({write_control, strap_bit_two, strap_bit_one, strap_bit_zero,
                sda_in, scl}),
    .q       (sync_w)
  );

  assign scl_s   = sync_w[0];
  assign sda_s   = sync_w[1];
  assign strap_s = sync_w[4:2];
  assign wc_s    = sync_w[5];

  always @(posedge clk) begin
    if (sys_rst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // The delay stage lets start and stop be seen as a data edge while the
  // link clock stays high in both samples, so a data change near a clock
  // edge is never taken for a start or a stop.
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_ev  = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // --------------------------------------------------------------------------
  // Storage.
  // --------------------------------------------------------------------------
  // The page buffer collects written bytes until the stop; a restart drops
  // them, and only a stop after accepted data starts the program cycle.
  reg [7:0]      mem [0:255];
  reg [7:0]      wbuf [0:PAGE-1];
  reg [2:0]      state_q;
  reg [1:0]      role_q;
  reg [3:0]      cnt_q;
  reg [7:0]      shift_q;
  reg [7:0]      ptr_q;
  reg            to_tx_q;
  reg            prot_sel_q;
  reg [PAGE-1:0] wmask_q;
  reg [3:0]      wpage_q;
  reg [7:0]      prot_q;
  reg [7:0]      prot_data_q;
  reg            prot_pend_q;
  reg [CW-1:0]   prog_cnt_q;
  reg [4:0]      commit_q;

  integer i;

  // Unprogrammed cells read as erased.
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      mem[i] = `PSDE_RST_ERASED;
    end
  end

  // The pin only ever pulls low; the busy flag is the running program count,
  // so it falls in the same cycle in which the count reaches zero.
  assign sda_out    = 1'b0;
  assign write_busy = |prog_cnt_q;

  // --------------------------------------------------------------------------
  // Fixed descriptor contents.
  // --------------------------------------------------------------------------
  function [7:0] rom_byte;
    input [3:0] a;
    begin
      case (a)
        `PSDE_OFS_BYTES_USED_COUNT:    rom_byte = `PSDE_RST_BYTES_USED_COUNT;
        `PSDE_OFS_TOTAL_SIZE_CODE:     rom_byte = `PSDE_RST_TOTAL_SIZE_CODE;
        `PSDE_OFS_MEMORY_TYPE_CODE:    rom_byte = `PSDE_RST_MEMORY_TYPE_CODE;
        `PSDE_OFS_ROW_ADDRESS_COUNT:   rom_byte = (DENSITY == 0) ?
          `PSDE_RST_ROW_SMALL : `PSDE_RST_ROW_LARGE;
        `PSDE_OFS_COLUMN_ADDR_COUNT:   rom_byte = (DENSITY == 2) ?
          `PSDE_RST_COL_LARGE : `PSDE_RST_COL_SMALL;
        `PSDE_OFS_RANK_COUNT:          rom_byte = `PSDE_RST_RANK_COUNT;
        `PSDE_OFS_DATA_WIDTH_LOW:      rom_byte = `PSDE_RST_DATA_WIDTH_LOW;
        `PSDE_OFS_DATA_WIDTH_HIGH:     rom_byte = `PSDE_RST_DATA_WIDTH_HIGH;
        `PSDE_OFS_SIGNAL_LEVEL_CODE:   rom_byte = `PSDE_RST_SIGNAL_LEVEL_CODE;
        `PSDE_OFS_CYCLE_TIME_MAX_LAT:  rom_byte = CYCLE_BYTE;
        `PSDE_OFS_ACCESS_TIME_MAX_LAT: rom_byte = ACCESS_BYTE;
        `PSDE_OFS_MODULE_CONFIG_TYPE:  rom_byte = `PSDE_RST_MODULE_CONFIG_TYPE;
        `PSDE_OFS_REFRESH_RATE_TYPE:   rom_byte = (DENSITY == 0) ?
          `PSDE_RST_REFRESH_SMALL : `PSDE_RST_REFRESH_LARGE;
        `PSDE_OFS_DEVICE_WIDTH:        rom_byte = `PSDE_RST_DEVICE_WIDTH;
        `PSDE_OFS_CHECK_DATA_WIDTH:    rom_byte = `PSDE_RST_CHECK_DATA_WIDTH;
        default:                       rom_byte = `PSDE_RST_ERASED;
      endcase
    end
  endfunction

  wire       in_rom  = ptr_q < `PSDE_ROM_SIZE;
  wire [7:0] rd_byte = prot_sel_q ? prot_q :
                       (in_rom ? rom_byte(ptr_q[3:0]) : mem[ptr_q]);

  // --------------------------------------------------------------------------
  // Select byte decode.
  // --------------------------------------------------------------------------
  // The decode is used at the falling edge after the eighth bit, when the
  // whole select byte sits in the shift register.
  wire strap_ok  = shift_q[3:1] == strap_s;
  wire array_hit = (shift_q[7:4] == `PSDE_DEVTYPE_ARRAY) & strap_ok;
  wire prot_hit  = (shift_q[7:4] == `PSDE_DEVTYPE_PROT) & strap_ok;

  // --------------------------------------------------------------------------
  // Commit of the page buffer during the program cycle.
  // --------------------------------------------------------------------------
  // One buffer slot is copied per cycle in the first sixteen cycles of the
  // program cycle; slots that were never written and descriptor bytes are
  // left untouched, so a write to the descriptor is taken but discarded.
  wire [7:0] commit_addr = {wpage_q, commit_q[3:0]};
  wire       commit_en   = write_busy & ~commit_q[4] & wmask_q[commit_q[3:0]] &
                           (commit_addr >= `PSDE_ROM_SIZE);

  always @(posedge clk) begin
    if (commit_en) begin
      mem[commit_addr] <= wbuf[commit_q[3:0]];
    end
  end

  // --------------------------------------------------------------------------
  // Bus engine.
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      role_q      <= RL_SEL;
      cnt_q       <= 4'h0;
      shift_q     <= 8'h00;
      ptr_q       <= 8'h00;
      to_tx_q     <= 1'b0;
      prot_sel_q  <= 1'b0;
      wmask_q     <= {PAGE{1'b0}};
      wpage_q     <= 4'h0;
      prot_q      <= 8'h00;
      prot_data_q <= 8'h00;
      prot_pend_q <= 1'b0;
      prog_cnt_q  <= {CW{1'b0}};
      commit_q    <= 5'h10;
      sda_oe      <= 1'b0;
    end else if (write_busy) begin
      // The bus is ignored and the data line released meanwhile.
      sda_oe     <= 1'b0;
      state_q    <= ST_IDLE;
      prog_cnt_q <= prog_cnt_q - 1'b1;
      if (!commit_q[4]) begin
        commit_q <= commit_q + 1'b1;
      end else begin
        wmask_q <= {PAGE{1'b0}};
      end
      if (prot_pend_q) begin
        prot_q      <= prot_data_q;
        prot_pend_q <= 1'b0;
      end
    end else if (start_ev) begin
      // A restart drops any unfinished write.
      state_q     <= ST_RX;
      role_q      <= RL_SEL;
      cnt_q       <= 4'h0;
      sda_oe      <= 1'b0;
      wmask_q     <= {PAGE{1'b0}};
      prot_pend_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= ST_IDLE;
      sda_oe  <= 1'b0;
      if ((|wmask_q) | prot_pend_q) begin
        prog_cnt_q <= PROG_LOAD;
        commit_q   <= 5'h00;
      end
    end else begin
      case (state_q)
        // Receive a byte, then decide at the falling edge whether to answer.
        ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            case (role_q)
              RL_SEL: begin
                if (array_hit | prot_hit) begin
                  sda_oe     <= 1'b1;
                  state_q    <= ST_ACK;
                  prot_sel_q <= prot_hit;
                  to_tx_q    <= shift_q[0];
                  role_q     <= prot_hit ? RL_DATA : RL_ADDR;
                end else begin
                  state_q <= ST_IDLE;
                end
              end
              RL_ADDR: begin
                ptr_q   <= shift_q;
                wpage_q <= shift_q[7:4];
                sda_oe  <= 1'b1;
                state_q <= ST_ACK;
                to_tx_q <= 1'b0;
                role_q  <= RL_DATA;
              end
              RL_DATA: begin
                if (!wc_s) begin
                  sda_oe  <= 1'b1;
                  state_q <= ST_ACK;
                  to_tx_q <= 1'b0;
                  if (prot_sel_q) begin
                    prot_data_q <= shift_q;
                    prot_pend_q <= 1'b1;
                  end else begin
                    wbuf[ptr_q[3:0]]    <= shift_q;
                    wmask_q[ptr_q[3:0]] <= 1'b1;
                    ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
                  end
                end else begin
                  state_q <= ST_IDLE;
                end
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        // Hold the acknowledge for the ninth clock, then send or receive.
        ST_ACK: begin
          if (scl_fall) begin
            if (to_tx_q) begin
              state_q <= ST_TX;
              shift_q <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              cnt_q   <= 4'h1;
              ptr_q   <= ptr_q + 8'h01;
            end else begin
              state_q <= ST_RX;
              sda_oe  <= 1'b0;
              cnt_q   <= 4'h0;
            end
          end
        end
        // Each falling edge puts the next bit on the wire.
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              sda_oe  <= 1'b0;
              state_q <= ST_MACK;
            end else begin
              sda_oe  <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q   <= cnt_q + 1'b1;
            end
          end
        end
        // The master's answer is taken at the rising edge of the ninth clock.
        // Without an acknowledge the block stays silent until the next start.
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_ACK;
              to_tx_q <= 1'b1;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** psde_master.sv ***
/*
  Two-wire bus master model; the link clock idles high between frames.
  Assumes sda is the resolved wire with a pull-up; acts on falling clk edges.
*/
module psde_master (
  input  wire  clk,
  input  wire  sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Start or repeated start; leaves the link clock low.
  task automatic start();
    sda_low = 1'h0;
    cyc(2);
    scl = 1'h1;
    cyc(4);
    sda_low = 1'h1;
    cyc(4);
    scl = 1'h0;
    cyc(2);
  endtask
  task automatic stop();
    sda_low = 1'h1;
    cyc(2);
    scl = 1'h1;
    cyc(4);
    sda_low = 1'h0;
    cyc(4);
  endtask
  // Data changes mid-low and is sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    cyc(2);
    scl = 1'h1;
    cyc(2);
    r = sda;
    cyc(2);
    scl = 1'h0;
    cyc(2);
  endtask
  task automatic put(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'h1, r);
    ack = !r;
  endtask
  task automatic get(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      v[i] = r;
    end
    bit_io(!mack, r);
  endtask
endmodule

// *** psde_asserts.sv ***
/*
  Pin checker for the presence-detect EEPROM slave.
  Assumes a bind to psde_top; sees its ports only.
*/
module psde_asserts #(
  parameter PROG_CYCLES = 40
) (
  input wire clk,
  input wire sys_rst,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire strap_bit_zero,
  input wire strap_bit_one,
  input wire strap_bit_two,
  input wire write_control,
  input wire write_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] busy_cnt_q;
  logic [3:0]  stop_age_q;
  logic        sda_prev_q;
  // --------
  // Program cycle length and time since the last stop.
  // --------
  always @(posedge clk) begin
    sda_prev_q <= sda_in;
    busy_cnt_q <= (sys_rst || !write_busy) ? 16'h0000 : busy_cnt_q + 16'h0001;
    if (sys_rst || stop_age_q != 4'hF) begin
      stop_age_q <= sys_rst ? 4'hF : stop_age_q + 4'h1;
    end
    if (scl && sda_in && !sda_prev_q) begin
      stop_age_q <= 4'h0;
    end
  end
  sequence stop_seen;
    scl && $rose(sda_in);
  endsequence
  sequence busy_begin;
    $rose(write_busy);
  endsequence
  sequence quiet8;
    !sda_oe [*8];
  endsequence
  busy_bound_a: assert property (write_busy |-> busy_cnt_q < PROG_CYCLES)
    else $error("program cycle too long");
  busy_exact_a: assert property (
    $fell(write_busy) |-> $past(busy_cnt_q) == PROG_CYCLES - 1)
    else $error("program cycle length wrong");
  busy_cause_a: assert property (busy_begin |-> stop_age_q < 4'hC)
    else $error("program cycle without stop");
  wc_gate_a: assert property (busy_begin |-> !$past(write_control, 4))
    else $error("write taken with write control high");
  busy_quiet_a: assert property (write_busy |-> !sda_oe)
    else $error("data driven during program cycle");
  drain_low_a: assert property (sda_oe |-> !sda_in)
    else $error("data pin not open drain");
  stop_idle_a: assert property (stop_seen |-> quiet8)
    else $error("data driven after stop");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data changed while link clock high");
endmodule

// *** psde_tb.sv ***
/*
  Self-checking bench for the presence-detect EEPROM slave.
  Assumes psde_top, psde_master and psde_asserts are compiled before it.
*/
module psde_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 200;
  localparam logic [7:0] ROM [15] = '{8'h80, 8'h08, 8'h07, 8'h0D, 8'h0A, 8'h01, 8'h40,
    8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        clk;
  logic        sys_rst;
  logic        write_control;
  logic        a;
  logic [2:0]  strap;
  logic [7:0]  d;
  logic [7:0]  base;
  logic [7:0]  pg [16];
  logic [31:0] lfsr_q;
  int          fails;
  int          n_checks;
  wire         m_scl;
  wire         m_low;
  wire         sda_out;
  wire         sda_oe;
  wire         write_busy;
  wire         sda;
  assign sda = !(m_low || (sda_oe && !sda_out));
  psde_top #(.DENSITY(1), .PROG_CYCLES(PC)) psde_top_inst (
    .clk(clk), .sys_rst(sys_rst), .scl(m_scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_bit_zero(strap[0]), .strap_bit_one(strap[1]),
    .strap_bit_two(strap[2]), .write_control(write_control), .write_busy(write_busy));
  psde_master psde_master_inst (.clk(clk), .sda(sda), .scl(m_scl), .sda_low(m_low));
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected byte at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected bit at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    psde_master_inst.put(b, a);
    chk_bit(a, exp);
  endtask
  task automatic sel(input logic [7:0] b, input logic exp);
    psde_master_inst.start();
    put(b, exp);
  endtask
  task automatic rd_at(input logic [7:0] adr);
    sel({4'hA, strap, 1'h0}, 1'h1);
    put(adr, 1'h1);
    sel({4'hA, strap, 1'h1}, 1'h1);
  endtask
  // Stop, then check the program cycle and wait for its end.
  task automatic settle(input logic on);
    psde_master_inst.stop();
    psde_master_inst.cyc(8);
    if (on) begin
      chk_bit(write_busy, 1'h1);
      sel({4'hA, strap, 1'h1}, 1'h0);
      psde_master_inst.stop();
    end
    for (int k = 0; k < 400 && write_busy !== 1'h0; k++) psde_master_inst.cyc(1);
    chk_bit(write_busy, 1'h0);
  endtask
  task automatic wr1(input logic [3:0] ty, input logic [7:0] adr, input logic [7:0] v,
                     input logic ok, input logic on);
    sel({ty, strap, 1'h0}, 1'h1);
    if (ty == 4'hA) put(adr, 1'h1);
    put(v, ok);
    settle(on);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = !clk;
  end
  initial begin
    #200us;
    fails++;
    final_report();
  end
  initial begin
    sys_rst = 1'h1;
    write_control = 1'h1;
    strap = 3'h5;
    lfsr_q = 32'h0001_0ECB;
    fails = 0;
    n_checks = 0;
    repeat (10) @(negedge clk);
    sys_rst = 1'h0;
    psde_master_inst.cyc(4);
    rd_at(8'h00);
    for (int i = 0; i < 16; i++) begin
      psde_master_inst.get(i < 14, d);
      if (!(i inside {9, 10, 12, 13})) chk(d, i < 15 ? ROM[i] : 8'hFF);
    end
    psde_master_inst.stop();
    sel({4'h5, strap, 1'h1}, 1'h0);
    sel({4'hA, ~strap, 1'h1}, 1'h0);
    psde_master_inst.stop();
    $display("test descriptor and select done");
    write_control = 1'h0;
    d = rnd();
    base = {d[7:4] | 4'h1, 4'h0};
    sel({4'hA, strap, 1'h0}, 1'h1);
    put(base, 1'h1);
    for (int i = 0; i < 16; i++) begin
      pg[i] = rnd();
      put(pg[i], 1'h1);
    end
    settle(1'h1);
    rd_at(base);
    for (int i = 0; i < 15; i++) begin
      psde_master_inst.get(i < 14, d);
      chk(d, pg[i]);
    end
    psde_master_inst.stop();
    sel({4'hA, strap, 1'h1}, 1'h1);
    psde_master_inst.get(1'h0, d);
    chk(d, pg[15]);
    psde_master_inst.stop();
    $display("test page write done");
    wr1(4'hA, 8'h00, rnd(), 1'h1, 1'h0);
    write_control = 1'h1;
    wr1(4'hA, base, ~pg[0], 1'h0, 1'h0);
    rd_at(base);
    psde_master_inst.get(1'h0, d);
    chk(d, pg[0]);
    psde_master_inst.stop();
    rd_at(8'h00);
    psde_master_inst.get(1'h0, d);
    chk(d, 8'h80);
    psde_master_inst.stop();
    $display("test refused writes done");
    write_control = 1'h0;
    d = rnd();
    wr1(4'h6, 8'h00, d, 1'h1, 1'h1);
    sel({4'h6, strap, 1'h1}, 1'h1);
    psde_master_inst.get(1'h0, base);
    chk(base, d);
    psde_master_inst.stop();
    $display("test protection byte done");
    final_report();
  end
endmodule
bind psde_top psde_asserts #(.PROG_CYCLES(PROG_CYCLES)) psde_asserts_inst (
  .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .strap_bit_zero(strap_bit_zero), .strap_bit_one(strap_bit_one),
  .strap_bit_two(strap_bit_two), .write_control(write_control), .write_busy(write_busy));
